//--- rtl/ulp_pkg.sv
package ulp_pkg;
   localparam int DATA_W = 8;
   localparam int WORD_W = DATA_W + 1;
   localparam int LAST_BIT = DATA_W;
   localparam int FIFO_DEPTH = 32;
   localparam int SYNC_LEN = 2;
   localparam logic [DATA_W-1:0] IDLE_BYTE = 8'h00;
   localparam logic [1:0] SEL_13M = 2'h0;
   localparam logic [1:0] SEL_19M2 = 2'h1;
   localparam logic [1:0] SEL_26M = 2'h2;
   localparam logic [1:0] SEL_24M = 2'h3;
   localparam int KHZ_W = 16;
   localparam logic [KHZ_W-1:0] KHZ_13M = 16'h32c8;
   localparam logic [KHZ_W-1:0] KHZ_19M2 = 16'h4b00;
   localparam logic [KHZ_W-1:0] KHZ_26M = 16'h6590;
   localparam logic [KHZ_W-1:0] KHZ_24M = 16'h5dc0;
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_RECV,
      ST_CLOSE,
      ST_TURN_OUT,
      ST_SEND,
      ST_TURN_IN
   } ulp_state_t;
endpackage

//--- rtl/ulp_fifo.sv
`timescale 1ns/100ps
module ulp_fifo #(
   parameter int W = 9,
   parameter int DEPTH = 32
) (
   input wire logic wclk_i,
   input wire logic wrst_n_i,
   input wire logic [W-1:0] in_data_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic rclk_i,
   input wire logic rrst_n_i,
   output logic [W-1:0] out_data_o,
   output logic out_valid_o,
   input wire logic out_ready_i
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem [DEPTH];
   logic [AW:0] wbin_q, wgray_q, rbin_q, rgray_q;
   logic [AW:0] wq1_q, wq2_q, rq1_q, rq2_q;
   logic ready_q, valid_q;
   logic [W-1:0] data_q;
   wire push = in_valid_i & ready_q;
   wire [AW:0] wbin_d = wbin_q + (AW+1)'(push);
   wire [AW:0] wgray_d = (wbin_d >> 1) ^ wbin_d;
   wire full_d = wgray_d == {~wq2_q[AW:AW-1], wq2_q[AW-2:0]};
   wire empty = rgray_q == rq2_q;
   wire pop = ~empty & (~valid_q | out_ready_i);
   wire [AW:0] rbin_d = rbin_q + (AW+1)'(pop);

   // Gray pointers cross; only the second stage is compared
   always_ff @(posedge wclk_i) begin
      if (push) begin
         mem[wbin_q[AW-1:0]] <= in_data_i;
      end
   end

   always_ff @(posedge wclk_i or negedge wrst_n_i) begin
      if (!wrst_n_i) begin
         wbin_q <= '0;
         wgray_q <= '0;
         wq1_q <= '0;
         wq2_q <= '0;
         ready_q <= 1'b0;
      end else begin
         wbin_q <= wbin_d;
         wgray_q <= wgray_d;
         wq1_q <= rgray_q;
         wq2_q <= wq1_q;
         ready_q <= ~full_d;
      end
   end

   always_ff @(posedge rclk_i or negedge rrst_n_i) begin
      if (!rrst_n_i) begin
         rbin_q <= '0;
         rgray_q <= '0;
         rq1_q <= '0;
         rq2_q <= '0;
      end else begin
         rbin_q <= rbin_d;
         rgray_q <= (rbin_d >> 1) ^ rbin_d;
         rq1_q <= wgray_q;
         rq2_q <= rq1_q;
      end
   end

   // Output word held in a register so the reader sees a clean flop
   always_ff @(posedge rclk_i or negedge rrst_n_i) begin
      if (!rrst_n_i) begin
         data_q <= '0;
         valid_q <= 1'b0;
      end else if (pop) begin
         data_q <= mem[rbin_q[AW-1:0]];
         valid_q <= 1'b1;
      end else if (out_ready_i) begin
         valid_q <= 1'b0;
      end
   end

   assign in_ready_o = ready_q;
   assign out_data_o = data_q;
   assign out_valid_o = valid_q;
endmodule // ulp_fifo

//--- rtl/ulp_phy_link.sv
`timescale 1ns/100ps
module ulp_phy_link
   import ulp_pkg::*;
(
   input wire logic CLK_SYS_I,
   input wire logic RESET_N_I,
   input wire logic LINK_CLK_I,
   input wire logic [1:0] REF_FREQ_SELECT_I,
   output logic [KHZ_W-1:0] REF_FREQ_KHZ_O,
   output logic REF_FREQ_VALID_O,
   output logic INTERFACE_CLOCK_OUT_O,
   output logic INTERFACE_CLOCK_OE_O,
   input wire logic [DATA_W-1:0] DATA_I,
   output logic [DATA_W-1:0] DATA_O,
   output logic DATA_OE_O,
   output logic DIR_O,
   output logic NXT_O,
   output logic CTRL_OE_O,
   input wire logic STP_I,
   input wire logic [DATA_W-1:0] SEND_DATA_I,
   input wire logic SEND_LAST_I,
   input wire logic SEND_VALID_I,
   output logic SEND_READY_O,
   output logic [DATA_W-1:0] RECV_DATA_O,
   output logic RECV_LAST_O,
   output logic RECV_VALID_O,
   input wire logic RECV_READY_I,
   output logic STREAM_ABORT_O
);

   // Reset release is synchronised separately in each domain

   logic [SYNC_LEN-1:0] srst_q;
   logic [SYNC_LEN-1:0] lrst_q;
   wire sys_rst_n = srst_q[SYNC_LEN-1];
   wire link_rst_n = lrst_q[SYNC_LEN-1];

   always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         srst_q <= '0;
      end else begin
         srst_q <= {srst_q[SYNC_LEN-2:0], 1'b1};
      end
   end

   always_ff @(posedge LINK_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         lrst_q <= '0;
      end else begin
         lrst_q <= {lrst_q[SYNC_LEN-2:0], 1'b1};
      end
   end

   // Interface clock and pad enables

   logic clk_en_q;
   logic ctrl_oe_q;

   // Gate enable changes on the falling edge so the clock only glitches when the asynchronous reset clears it
   always_ff @(negedge LINK_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         clk_en_q <= 1'b0;
      end else begin
         clk_en_q <= link_rst_n;
      end
   end

   always_ff @(posedge LINK_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         ctrl_oe_q <= 1'b0;
      end else begin
         ctrl_oe_q <= link_rst_n;
      end
   end

   // The forwarded clock is a gated copy, not a flop, to keep it at rate
   assign INTERFACE_CLOCK_OUT_O = LINK_CLK_I & clk_en_q;
   assign INTERFACE_CLOCK_OE_O = clk_en_q;
   assign CTRL_OE_O = ctrl_oe_q;

   // Reference frequency straps

   logic [1:0] strap_s1_q;
   logic [1:0] strap_s2_q;
   logic strap_done_q;
   logic [KHZ_W-1:0] ref_khz_q;
   logic [KHZ_W-1:0] ref_khz_d;

   // No reset: the pins are already settled here when release arrives
   always_ff @(posedge CLK_SYS_I) begin
      strap_s1_q <= REF_FREQ_SELECT_I;
      strap_s2_q <= strap_s1_q;
   end

   always_comb begin
      unique case (strap_s2_q)
         SEL_13M: ref_khz_d = KHZ_13M;
         SEL_19M2: ref_khz_d = KHZ_19M2;
         SEL_26M: ref_khz_d = KHZ_26M;
         SEL_24M: ref_khz_d = KHZ_24M;
      endcase
   end

   // Sampled once after release; later strap changes are ignored
   always_ff @(posedge CLK_SYS_I or negedge sys_rst_n) begin
      if (!sys_rst_n) begin
         strap_done_q <= 1'b0;
         ref_khz_q <= '0;
      end else if (!strap_done_q) begin
         strap_done_q <= 1'b1;
         ref_khz_q <= ref_khz_d;
      end
   end

   assign REF_FREQ_KHZ_O = ref_khz_q;
   assign REF_FREQ_VALID_O = strap_done_q;

   // Buffers between the system side and the link side

   logic [WORD_W-1:0] s_word;
   logic s_valid;
   logic s_ready;
   logic [WORD_W-1:0] r_word;
   logic r_valid;
   logic r_ready;
   logic [WORD_W-1:0] recv_word;

   ulp_fifo #(
      .W(WORD_W),
      .DEPTH(FIFO_DEPTH)
   ) u_send_fifo (
      .wclk_i(CLK_SYS_I),
      .wrst_n_i(sys_rst_n),
      .in_data_i({SEND_LAST_I, SEND_DATA_I}),
      .in_valid_i(SEND_VALID_I),
      .in_ready_o(SEND_READY_O),
      .rclk_i(LINK_CLK_I),
      .rrst_n_i(link_rst_n),
      .out_data_o(s_word),
      .out_valid_o(s_valid),
      .out_ready_i(s_ready)
   );

   ulp_fifo #(
      .W(WORD_W),
      .DEPTH(FIFO_DEPTH)
   ) u_recv_fifo (
      .wclk_i(LINK_CLK_I),
      .wrst_n_i(link_rst_n),
      .in_data_i(r_word),
      .in_valid_i(r_valid),
      .in_ready_o(r_ready),
      .rclk_i(CLK_SYS_I),
      .rrst_n_i(sys_rst_n),
      .out_data_o(recv_word),
      .out_valid_o(RECV_VALID_O),
      .out_ready_i(RECV_READY_I)
   );

   assign RECV_DATA_O = recv_word[DATA_W-1:0];
   assign RECV_LAST_O = recv_word[LAST_BIT];

   // Link side state machine

   ulp_state_t state_q, state_d;
   logic dir_q;
   logic nxt_q;
   logic data_oe_q;
   logic [DATA_W-1:0] data_q;
   logic sent_last_q;
   logic drop_q;
   logic pend_q;
   logic [DATA_W-1:0] pend_data_q;
   logic abort_tgl_q;

   wire [DATA_W-1:0] s_data = s_word[DATA_W-1:0];
   wire s_last = s_word[LAST_BIT];
   wire st_idle = state_q == ST_IDLE;
   wire st_recv = state_q == ST_RECV;
   wire st_close = state_q == ST_CLOSE;
   wire st_send = state_q == ST_SEND;
   wire st_turn_out = state_q == ST_TURN_OUT;
   wire cmd_seen = st_idle & (DATA_I != IDLE_BYTE) & ~drop_q;
   wire send_go = st_idle & ~cmd_seen & s_valid & ~drop_q;
   wire take = st_recv & nxt_q & ~STP_I;
   wire recv_end = st_recv & STP_I;
   wire close_push = st_close & pend_q & r_ready;
   wire push_now = (take & pend_q) | close_push;
   wire fill = st_turn_out | (st_send & ~sent_last_q & ~STP_I);
   wire send_abort = st_send & STP_I;
   wire send_done = st_send & sent_last_q & ~STP_I;
   wire drop_pop = st_idle & drop_q & s_valid;
   // One beat is skipped after each push so ready can catch up
   wire nxt_recv = (state_d == ST_RECV) & r_ready & ~push_now;

   assign s_ready = (fill & s_valid) | drop_pop;
   assign r_valid = push_now;
   assign r_word = {st_close, pend_data_q};

   always_comb begin
      unique case (state_q)
         ST_IDLE: begin
            if (cmd_seen) begin
               state_d = ST_RECV;
            end else if (send_go) begin
               state_d = ST_TURN_OUT;
            end else begin
               state_d = ST_IDLE;
            end
         end
         ST_RECV: state_d = recv_end ? ST_CLOSE : ST_RECV;
         ST_CLOSE: state_d = (!pend_q || r_ready) ? ST_IDLE : ST_CLOSE;
         ST_TURN_OUT: state_d = ST_SEND;
         ST_SEND: begin
            if (send_abort || send_done) begin
               state_d = ST_TURN_IN;
            end else begin
               state_d = ST_SEND;
            end
         end
         ST_TURN_IN: state_d = ST_IDLE;
         default: state_d = ST_IDLE;
      endcase
   end

   always_ff @(posedge LINK_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         state_q <= ST_IDLE;
      end else if (!link_rst_n) begin
         state_q <= ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // Bus direction: high from the turnaround until the send ends
   always_ff @(posedge LINK_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         dir_q <= 1'b0;
      end else if (send_go) begin
         dir_q <= 1'b1;
      end else if (send_abort || send_done) begin
         dir_q <= 1'b0;
      end
   end

   // Data pads driven only after the turnaround cycle
   always_ff @(posedge LINK_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         data_oe_q <= 1'b0;
      end else if (fill) begin
         data_oe_q <= 1'b1;
      end else begin
         data_oe_q <= 1'b0;
      end
   end

   // An empty send buffer mid-packet shows as idle data with NXT low
   always_ff @(posedge LINK_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         data_q <= IDLE_BYTE;
         sent_last_q <= 1'b0;
      end else if (fill && s_valid) begin
         data_q <= s_data;
         sent_last_q <= s_last;
      end else if (fill) begin
         data_q <= IDLE_BYTE;
      end else begin
         data_q <= IDLE_BYTE;
         sent_last_q <= 1'b0;
      end
   end

   always_ff @(posedge LINK_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         nxt_q <= 1'b0;
      end else if (fill) begin
         nxt_q <= s_valid;
      end else begin
         nxt_q <= nxt_recv;
      end
   end

   // The byte taken under NXT waits until STP tells whether it was last
   always_ff @(posedge LINK_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         pend_q <= 1'b0;
         pend_data_q <= IDLE_BYTE;
      end else if (take) begin
         pend_q <= 1'b1;
         pend_data_q <= DATA_I;
      end else if (close_push) begin
         pend_q <= 1'b0;
      end
   end

   // Remainder of an aborted packet is discarded up to its last byte
   always_ff @(posedge LINK_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         drop_q <= 1'b0;
      end else if (send_abort) begin
         drop_q <= ~sent_last_q;
      end else if (drop_pop && s_last) begin
         drop_q <= 1'b0;
      end
   end

   always_ff @(posedge LINK_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         abort_tgl_q <= 1'b0;
      end else if (send_abort) begin
         abort_tgl_q <= ~abort_tgl_q;
      end
   end

   assign DIR_O = dir_q;
   assign NXT_O = nxt_q;
   assign DATA_O = data_q;
   assign DATA_OE_O = data_oe_q;

   // Abort event crosses as a toggle

   logic abort_s1_q;
   logic abort_s2_q;
   logic abort_s3_q;
   logic abort_pulse_q;

   always_ff @(posedge CLK_SYS_I or negedge sys_rst_n) begin
      if (!sys_rst_n) begin
         abort_s1_q <= 1'b0;
         abort_s2_q <= 1'b0;
         abort_s3_q <= 1'b0;
         abort_pulse_q <= 1'b0;
      end else begin
         abort_s1_q <= abort_tgl_q;
         abort_s2_q <= abort_s1_q;
         abort_s3_q <= abort_s2_q;
         abort_pulse_q <= abort_s2_q ^ abort_s3_q;
      end
   end

   assign STREAM_ABORT_O = abort_pulse_q;

endmodule // ulp_phy_link

//--- test/ulp_link_model.sv
`timescale 1ns/100ps
module ulp_link_model
   import ulp_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic dir_i,
   input wire logic nxt_i,
   input wire logic data_oe_i,
   input wire logic [DATA_W-1:0] data_i,
   output logic [DATA_W-1:0] data_o,
   output logic stp_o
);
   logic [DATA_W-1:0] tx_q[$];
   logic [DATA_W-1:0] rx_q[$];
   bit busy;
   bit abort;
   // Runs off the device's own clock output, as a real link would
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         busy = 0;
         stp_o <= 1'b0;
         data_o <= IDLE_BYTE;
      end else begin
         stp_o <= 1'b0;
         // The byte standing in the stop cycle is not data
         if (dir_i && data_oe_i && nxt_i && !stp_o) begin
            rx_q.push_back(data_i);
            if (abort) stp_o <= 1'b1;
         end else if (!dir_i && busy && nxt_i) begin
            if (tx_q.size() > 0) data_o <= tx_q.pop_front();
            else begin
               data_o <= IDLE_BYTE;
               stp_o <= 1'b1;
               busy = 0;
            end
         end else if (!dir_i && !busy && tx_q.size() > 0 && !stp_o) begin
            data_o <= tx_q.pop_front();
            busy = 1;
         end
      end
   end
endmodule // ulp_link_model

//--- test/ulp_phy_link_assertions.sv
`timescale 1ns/100ps
module ulp_phy_link_assertions
   import ulp_pkg::*;
(
   input wire logic CLK_SYS_I,
   input wire logic RESET_N_I,
   input wire logic LINK_CLK_I,
   input wire logic [KHZ_W-1:0] REF_FREQ_KHZ_O,
   input wire logic REF_FREQ_VALID_O,
   input wire logic INTERFACE_CLOCK_OE_O,
   input wire logic [DATA_W-1:0] DATA_O,
   input wire logic DATA_OE_O,
   input wire logic DIR_O,
   input wire logic NXT_O,
   input wire logic CTRL_OE_O,
   input wire logic STP_I
);
   // Reset itself is the subject here, so it cannot disable the check
   reset_float_a: assert property (@(posedge CLK_SYS_I)
      !RESET_N_I |-> !(DATA_OE_O | CTRL_OE_O | INTERFACE_CLOCK_OE_O | DIR_O))
      else $error("pins driven in reset");
   oe_needs_dir_a: assert property (@(posedge LINK_CLK_I) disable iff (!RESET_N_I)
      DATA_OE_O |-> DIR_O) else $error("bus driven with direction low");
   bus_turnaround_a: assert property (@(posedge LINK_CLK_I) disable iff (!RESET_N_I)
      $rose(DIR_O) |-> !DATA_OE_O ##1 DATA_OE_O) else $error("bad turnaround");
   stp_ends_send_a: assert property (@(posedge LINK_CLK_I) disable iff (!RESET_N_I)
      STP_I && DATA_OE_O |=> !DIR_O) else $error("send kept after stop");
   stp_stops_nxt_a: assert property (@(posedge LINK_CLK_I) disable iff (!RESET_N_I)
      STP_I && !DIR_O |=> !NXT_O) else $error("byte taken after stop");
   send_nxt_oe_a: assert property (@(posedge LINK_CLK_I) disable iff (!RESET_N_I)
      DIR_O && NXT_O |-> DATA_OE_O) else $error("next without data");
   idle_byte_a: assert property (@(posedge LINK_CLK_I) disable iff (!RESET_N_I)
      !DATA_OE_O |-> DATA_O == IDLE_BYTE) else $error("released bus not idle");
   strap_hold_a: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
      REF_FREQ_VALID_O |=> REF_FREQ_VALID_O && $stable(REF_FREQ_KHZ_O))
      else $error("strap value moved");
   send_c: cover property (@(posedge LINK_CLK_I) $rose(DIR_O));
   stop_c: cover property (@(posedge LINK_CLK_I) STP_I && !DIR_O);
   abort_c: cover property (@(posedge LINK_CLK_I) STP_I && DIR_O);
endmodule // ulp_phy_link_assertions
bind ulp_phy_link ulp_phy_link_assertions ulp_phy_link_assertions_inst (.*);

//--- test/test_ulp_phy_link.sv
`timescale 1ns/100ps
module test_ulp_phy_link import ulp_pkg::*;;
   logic CLK_SYS_I, RESET_N_I, LINK_CLK_I, REF_FREQ_VALID_O, INTERFACE_CLOCK_OUT_O;
   logic INTERFACE_CLOCK_OE_O, DATA_OE_O, DIR_O, NXT_O, CTRL_OE_O, STP_I;
   logic SEND_LAST_I, SEND_VALID_I, SEND_READY_O, RECV_LAST_O, RECV_VALID_O;
   logic STREAM_ABORT_O;
   logic RECV_READY_I = 1'b0;
   logic [1:0] REF_FREQ_SELECT_I;
   logic [KHZ_W-1:0] REF_FREQ_KHZ_O;
   logic [DATA_W-1:0] DATA_I, DATA_O, SEND_DATA_I, RECV_DATA_O, link_d, pad_q;
   int mismatches, checked, aborts, n, i, k;
   bit rr_on;
   logic [8:0] w;
   logic [8:0] exp_r[$];
   logic [8:0] got_r[$];
   logic [7:0] exp_l[$];
   int khz_tab[4] = '{13000, 19200, 26000, 24000};
   ulp_phy_link ulp_phy_link_inst (.*);
   ulp_link_model ulp_link_model_inst (
      .clk_i(INTERFACE_CLOCK_OUT_O),
      .rst_n_i(RESET_N_I),
      .dir_i(DIR_O),
      .nxt_i(NXT_O),
      .data_oe_i(DATA_OE_O),
      .data_i(DATA_I),
      .data_o(link_d),
      .stp_o(STP_I)
   );
   // No keeper on the bus: a released bus shows a changing pattern
   assign DATA_I = DATA_OE_O ? DATA_O : (!DIR_O ? link_d : ~pad_q);
   always @(posedge LINK_CLK_I) pad_q <= DATA_I;
   initial begin
      CLK_SYS_I = 0;
      forever #5 CLK_SYS_I = ~CLK_SYS_I;
   end
   initial begin
      LINK_CLK_I = 0;
      #1;
      forever begin
         LINK_CLK_I = ~LINK_CLK_I;
         #15;
      end
   end
   always @(negedge CLK_SYS_I) RECV_READY_I <= rr_on ? 1'($urandom) : 1'b0;
   always @(posedge CLK_SYS_I) begin
      if (STREAM_ABORT_O === 1'b1) aborts++;
      if (RECV_VALID_O === 1'b1 && RECV_READY_I) got_r.push_back({RECV_LAST_O, RECV_DATA_O});
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic summarize();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic await(input int nl, input int nr, input int na);
      for (k = 0; k < 20000; k++) begin
         if (ulp_link_model_inst.rx_q.size() >= nl && got_r.size() >= nr && aborts >= na) return;
         @(negedge CLK_SYS_I);
      end
      mismatches++;
      summarize();
   endtask
   task automatic send(input logic [7:0] d, input logic l);
      @(negedge CLK_SYS_I);
      SEND_VALID_I = 1;
      SEND_DATA_I = d;
      SEND_LAST_I = l;
      for (k = 0; k < 20000 && SEND_READY_O !== 1'b1; k++) @(posedge CLK_SYS_I);
      if (k == 20000) begin
         mismatches++;
         summarize();
      end
      if (k == 0) @(posedge CLK_SYS_I);
      exp_l.push_back(d);
      @(negedge CLK_SYS_I);
      SEND_VALID_I = 0;
   endtask
   task automatic do_reset(input logic [1:0] s, input int c);
      @(negedge CLK_SYS_I);
      RESET_N_I = 0;
      REF_FREQ_SELECT_I = s;
      repeat (c) @(posedge CLK_SYS_I);
      chk({DIR_O, DATA_OE_O, CTRL_OE_O, INTERFACE_CLOCK_OE_O}, 0);
      @(negedge CLK_SYS_I);
      RESET_N_I = 1;
   endtask
   initial begin
      RESET_N_I = 0;
      REF_FREQ_SELECT_I = 0;
      SEND_VALID_I = 0;
      SEND_DATA_I = 0;
      SEND_LAST_I = 0;
      void'($urandom(32'h921d_6e0b));
      for (i = 0; i < 4; i++) begin
         // Later resets are longer so the slow link clock sees three edges
         do_reset(i[1:0], i == 0 ? 6 : 10);
         repeat (5) @(posedge CLK_SYS_I);
         chk(REF_FREQ_KHZ_O, khz_tab[i]);
         chk(REF_FREQ_VALID_O, 1);
         $display("strap test %0d done", i);
      end
      repeat (20) @(negedge CLK_SYS_I);
      for (i = 0; i < 40; i++) begin
         w = {1'(i == 39), 8'($urandom) | (i == 0 ? 8'h40 : 8'h00)};
         ulp_link_model_inst.tx_q.push_back(w[7:0]);
         exp_r.push_back(w);
      end
      repeat (20) @(negedge CLK_SYS_I);
      n = 0;
      w = 9'($urandom);
      for (i = 0; i < 40; i++) begin
         @(negedge CLK_SYS_I);
         SEND_VALID_I = 1;
         SEND_DATA_I = w[7:0];
         SEND_LAST_I = 0;
         @(posedge CLK_SYS_I);
         if (SEND_READY_O === 1'b1) begin
            exp_l.push_back(w[7:0]);
            n++;
            w = 9'($urandom);
         end
      end
      // The output register holds one word beyond the array
      chk(n, FIFO_DEPTH + 1);
      rr_on = 1;
      send(8'h5a, 1);
      await(FIFO_DEPTH + 2, 40, 0);
      chk(got_r.size(), 40);
      foreach (exp_r[j]) chk(got_r[j], exp_r[j]);
      $display("two way test done");
      ulp_link_model_inst.abort = 1;
      for (i = 0; i < 4; i++) send(8'($urandom), 1'(i == 3));
      await(FIFO_DEPTH + 3, 40, 1);
      ulp_link_model_inst.abort = 0;
      repeat (3) void'(exp_l.pop_back());
      send(8'h3c, 0);
      send(8'hc3, 1);
      await(FIFO_DEPTH + 5, 40, 1);
      chk(aborts, 1);
      chk(ulp_link_model_inst.rx_q.size(), FIFO_DEPTH + 5);
      foreach (exp_l[j]) chk(ulp_link_model_inst.rx_q[j], exp_l[j]);
      chk(DIR_O, 0);
      $display("abort test done");
      summarize();
   end
endmodule // test_ulp_phy_link
